// [hdl/i2c_divider_device.sv]
// Function
// - Data changes only while clock low
// - Start and stop framed by data edges
// - Repeated start restarts without going idle
// - Bytes of eight bits, MSB first, unlimited
// - Ninth clock carries receiver acknowledge
// - Not-acknowledge only on address mismatch
// - Master acknowledges final read byte
// - Master not-acknowledge makes device send more
// - Seven address bits then direction bit
// - Register address is one byte
// - Address auto-increments per word, wraps
// - Words are two bytes, high first
// - Reads start from counter, zero at reset
// - Auto-increment advised for contiguous writes
// - Post-divider in bits 15:3 of 0x05
// - Driver select in bits 2:0, reset zero
// - Unused upper bits of 0x06 read zero
// - Second divider bit 3, driver bits 2:0
`timescale 1ns/10ps
module i2c_divider_device #(
  parameter logic [6:0] DEVICE_ADDR = divreg_pkg::DEVICE_ADDR_DEFAULT,
  parameter logic [12:0] POST_DIV_INIT = divreg_pkg::POST_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Serial link
  i2c_link_if.device link,
  // Divider and driver settings
  output logic [12:0] output_post_divider_o,
  output logic [2:0] post_driver_select_o,
  output logic second_output_divider_o,
  output logic [2:0] second_driver_select_o
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_REG,
    S_REG_ACK,
    S_WDATA,
    S_WDATA_ACK,
    S_RDATA,
    S_RDATA_ACK,
    S_RDONE
  } dev_state_type;

  typedef struct packed {
    dev_state_type st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic lo_byte;
    logic master_ack;
    logic [7:0] reg_addr;
    logic [7:0] hi_data;
    logic sda_oe;
    logic [12:0] post_div;
    logic [2:0] post_drv;
    logic second_div;
    logic [2:0] second_drv;
  } dev_regs_type;

  dev_regs_type s;
  dev_regs_type next_s;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;
  logic [15:0] write_word;

  // ****************************************************************
  // Line sampling
  // ****************************************************************
  line_sampler sampler (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .scl_pin_i(link.scl),
    .sda_pin_i(link.sda),
    .scl_o(),
    .sda_o(sda_level),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_seen),
    .stop_o(stop_seen)
  );

  // ****************************************************************
  // Register read view
  // ****************************************************************
  function automatic logic [15:0] word_at(input logic [7:0] addr);
    logic [15:0] w;
    w = '0;
    if (addr == divreg_pkg::REG_POST_DIV_ADDR) begin
      w[divreg_pkg::POST_DIV_MSB:divreg_pkg::POST_DIV_LSB] =
        s.post_div;
      w[divreg_pkg::DRIVER_MSB:divreg_pkg::DRIVER_LSB] = s.post_drv;
    end else if (addr == divreg_pkg::REG_SECOND_DIV_ADDR) begin
      // Bits above the divider select stay zero
      w[divreg_pkg::SECOND_DIV_BIT] = s.second_div;
      w[divreg_pkg::DRIVER_MSB:divreg_pkg::DRIVER_LSB] = s.second_drv;
    end
    return w;
  endfunction

  function automatic logic [7:0] byte_of(input logic [15:0] w,
                                         input logic lo);
    return lo ? w[7:0] : w[15:8];
  endfunction

  assign write_word = {s.hi_data, s.shift};

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  always_comb begin
    next_s = s;
    if (start_seen) begin
      // A repeated start lands here from any state
      next_s.st = S_ADDR;
      next_s.bit_cnt = '0;
      next_s.sda_oe = 1'h0;
      next_s.lo_byte = 1'h0;
    end else if (stop_seen) begin
      // A half-written word is dropped here
      next_s.st = S_IDLE;
      next_s.sda_oe = 1'h0;
    end else begin
      case (s.st)
        S_ADDR, S_REG, S_WDATA: begin
          if (scl_rise && s.bit_cnt != divreg_pkg::BITS_PER_BYTE) begin
            // Sample on the rising edge, MSB first
            next_s.shift = {s.shift[6:0], sda_level};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall &&
                       s.bit_cnt == divreg_pkg::BITS_PER_BYTE) begin
            next_s.bit_cnt = '0;
            next_s.sda_oe = 1'h1;
            if (s.st == S_ADDR) begin
              if (s.shift[7:1] == DEVICE_ADDR) begin
                next_s.rw = s.shift[0];
                next_s.st = S_ADDR_ACK;
              end else begin
                // Mismatch: leave the line high and sit out
                next_s.sda_oe = 1'h0;
                next_s.st = S_IDLE;
              end
            end else if (s.st == S_REG) begin
              next_s.reg_addr = s.shift;
              next_s.lo_byte = 1'h0;
              next_s.st = S_REG_ACK;
            end else begin
              if (!s.lo_byte) begin
                next_s.hi_data = s.shift;
              end
              next_s.st = S_WDATA_ACK;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            if (s.rw == divreg_pkg::RW_READ) begin
              // Counter left from the last access picks the word
              next_s.shift = byte_of(word_at(s.reg_addr), 1'h0);
              next_s.sda_oe = !next_s.shift[7];
              next_s.lo_byte = 1'h0;
              next_s.st = S_RDATA;
            end else begin
              next_s.sda_oe = 1'h0;
              next_s.st = S_REG;
            end
          end
        end
        S_REG_ACK: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'h0;
            next_s.st = S_WDATA;
          end
        end
        S_WDATA_ACK: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'h0;
            next_s.st = S_WDATA;
            next_s.lo_byte = !s.lo_byte;
            if (s.lo_byte) begin
              // Commit only once both bytes are acknowledged
              if (s.reg_addr == divreg_pkg::REG_POST_DIV_ADDR) begin
                next_s.post_div = write_word[divreg_pkg::POST_DIV_MSB:
                                             divreg_pkg::POST_DIV_LSB];
                next_s.post_drv = write_word[divreg_pkg::DRIVER_MSB:
                                             divreg_pkg::DRIVER_LSB];
              end else if (s.reg_addr == divreg_pkg::REG_SECOND_DIV_ADDR)
              begin
                // Upper bits of the word are discarded
                next_s.second_div = write_word[divreg_pkg::SECOND_DIV_BIT];
                next_s.second_drv = write_word[divreg_pkg::DRIVER_MSB:
                                               divreg_pkg::DRIVER_LSB];
              end
              next_s.reg_addr = s.reg_addr + 8'h01;
            end
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (s.bit_cnt == divreg_pkg::BITS_PER_BYTE) begin
              next_s.sda_oe = 1'h0;
              next_s.bit_cnt = '0;
              next_s.st = S_RDATA_ACK;
            end else begin
              next_s.shift = {s.shift[6:0], 1'h1};
              next_s.sda_oe = !s.shift[6];
            end
          end
        end
        S_RDATA_ACK: begin
          if (scl_rise) begin
            next_s.master_ack = !sda_level;
          end else if (scl_fall) begin
            if (!s.lo_byte) begin
              next_s.lo_byte = 1'h1;
              next_s.shift = byte_of(word_at(s.reg_addr), 1'h1);
              next_s.sda_oe = !next_s.shift[7];
              next_s.st = S_RDATA;
            end else begin
              next_s.lo_byte = 1'h0;
              next_s.reg_addr = s.reg_addr + 8'h01;
              if (s.master_ack) begin
                // Acknowledged word end: let go of the line
                next_s.st = S_RDONE;
              end else begin
                // No acknowledge: carry on with the next word, which may
                // hold the line low and block a stop
                next_s.shift = byte_of(word_at(s.reg_addr + 8'h01), 1'h0);
                next_s.sda_oe = !next_s.shift[7];
                next_s.st = S_RDATA;
              end
            end
          end
        end
        S_IDLE, S_RDONE: begin
          next_s.sda_oe = 1'h0;
        end
        default: begin
          next_s.st = S_IDLE;
          next_s.sda_oe = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= S_IDLE;
      s.reg_addr <= divreg_pkg::REG_ADDR_RESET;
      s.post_div <= POST_DIV_INIT;
      s.post_drv <= divreg_pkg::DRIVER_RESET;
      s.second_div <= divreg_pkg::SECOND_DIV_RESET;
      s.second_drv <= divreg_pkg::DRIVER_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.sda_dev_o = 1'h0;
  assign link.sda_dev_oe = s.sda_oe;
  assign output_post_divider_o = s.post_div;
  assign post_driver_select_o = s.post_drv;
  assign second_output_divider_o = s.second_div;
  assign second_driver_select_o = s.second_drv;

endmodule

// [hdl/i2c_divider_host.sv]
`timescale 1ns/10ps
module i2c_divider_host (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Command
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [6:0] cmd_dev_addr_i,
  input wire logic [7:0] cmd_reg_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic cmd_ready_o,
  // Result
  output logic done_o,
  output logic nack_o,
  output logic [15:0] rd_data_o,
  // Serial link
  i2c_link_if.host link
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_BIT,
    H_RSTART,
    H_STOP
  } host_state_type;

  typedef struct packed {
    host_state_type st;
    logic [1:0] ph;
    logic [8:0] tick;
    logic [3:0] bit_cnt;
    logic [2:0] step;
    logic is_read;
    logic [6:0] dev;
    logic [7:0] reg_addr;
    logic [15:0] wdata;
    logic [7:0] tx;
    logic [7:0] rx;
    logic scl_oe;
    logic sda_oe;
    logic [15:0] rd_data;
    logic nack;
    logic done;
  } host_regs_type;

  host_regs_type s;
  host_regs_type next_s;
  logic sda_level;
  logic receiving;
  logic [2:0] next_step;

  line_sampler sampler (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .scl_pin_i(link.scl),
    .sda_pin_i(link.sda),
    .scl_o(),
    .sda_o(sda_level),
    .scl_rise_o(),
    .scl_fall_o(),
    .start_o(),
    .stop_o()
  );

  // Byte sent at each step; a read first writes the register address
  function automatic logic [7:0] byte_for(input logic [2:0] step);
    case (step)
      divreg_pkg::STEP_DEV_WRITE: return {s.dev, divreg_pkg::RW_WRITE};
      divreg_pkg::STEP_REG: return s.reg_addr;
      divreg_pkg::STEP_THIRD: return s.is_read ?
        {s.dev, divreg_pkg::RW_READ} : s.wdata[15:8];
      divreg_pkg::STEP_FOURTH: return s.is_read ?
        divreg_pkg::BYTE_RELEASED : s.wdata[7:0];
      default: return divreg_pkg::BYTE_RELEASED;
    endcase
  endfunction

  assign receiving = s.is_read && (s.step >= divreg_pkg::STEP_FOURTH);
  assign next_step = s.step + 3'h1;

  // ****************************************************************
  // Sequencer, four quarter phases per bit
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.done = 1'h0;
    if (s.st == H_IDLE) begin
      if (cmd_valid_i) begin
        next_s.st = H_START;
        next_s.ph = '0;
        next_s.tick = divreg_pkg::SCL_QUARTER_LOAD;
        next_s.step = divreg_pkg::STEP_DEV_WRITE;
        next_s.is_read = cmd_read_i;
        next_s.dev = cmd_dev_addr_i;
        next_s.reg_addr = cmd_reg_addr_i;
        next_s.wdata = cmd_wdata_i;
        next_s.tx = {cmd_dev_addr_i, divreg_pkg::RW_WRITE};
        next_s.bit_cnt = '0;
        next_s.nack = 1'h0;
      end
    end else if (s.tick != '0) begin
      next_s.tick = s.tick - 9'h001;
    end else begin
      next_s.tick = divreg_pkg::SCL_QUARTER_LOAD;
      next_s.ph = s.ph + 2'h1;
      case (s.st)
        H_START: begin
          if (s.ph == 2'h0) begin
            next_s.sda_oe = 1'h1;
          end else begin
            next_s.scl_oe = 1'h1;
            next_s.st = H_BIT;
            next_s.ph = '0;
          end
        end
        H_BIT: begin
          case (s.ph)
            2'h0: begin
              next_s.scl_oe = 1'h1;
              // Data moves only in the low phase
              if (s.bit_cnt == divreg_pkg::BITS_PER_BYTE) begin
                next_s.sda_oe = receiving;
              end else begin
                next_s.sda_oe = !receiving && !s.tx[7];
              end
            end
            2'h1: next_s.scl_oe = 1'h0;
            2'h2: begin
              if (s.bit_cnt != divreg_pkg::BITS_PER_BYTE) begin
                next_s.rx = {s.rx[6:0], sda_level};
                next_s.tx = {s.tx[6:0], 1'h1};
              end else if (!receiving && sda_level) begin
                next_s.nack = 1'h1;
              end
            end
            default: begin
              next_s.scl_oe = 1'h1;
              next_s.bit_cnt = s.bit_cnt + 4'h1;
              if (s.bit_cnt == divreg_pkg::BITS_PER_BYTE) begin
                next_s.bit_cnt = '0;
                next_s.step = next_step;
                next_s.tx = byte_for(next_step);
                if (s.step == divreg_pkg::STEP_FOURTH && receiving) begin
                  next_s.rd_data[15:8] = s.rx;
                end
                if (s.step == divreg_pkg::STEP_FIFTH) begin
                  next_s.rd_data[7:0] = s.rx;
                end
                // One word per frame, so no auto-increment spill
                if (s.nack || s.step == divreg_pkg::STEP_FIFTH ||
                    (!s.is_read && s.step == divreg_pkg::STEP_FOURTH)) begin
                  next_s.st = H_STOP;
                end else if (s.is_read && s.step == divreg_pkg::STEP_REG)
                begin
                  next_s.st = H_RSTART;
                end
              end
            end
          endcase
        end
        H_RSTART: begin
          case (s.ph)
            2'h0: next_s.sda_oe = 1'h0;
            2'h1: next_s.scl_oe = 1'h0;
            2'h2: next_s.sda_oe = 1'h1;
            default: begin
              next_s.scl_oe = 1'h1;
              next_s.st = H_BIT;
            end
          endcase
        end
        H_STOP: begin
          case (s.ph)
            2'h0: begin
              next_s.scl_oe = 1'h1;
              next_s.sda_oe = 1'h1;
            end
            2'h1: next_s.scl_oe = 1'h0;
            2'h2: next_s.sda_oe = 1'h0;
            default: begin
              next_s.st = H_IDLE;
              next_s.done = 1'h1;
            end
          endcase
        end
        default: next_s.st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= H_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready_o = (s.st == H_IDLE);
  assign done_o = s.done;
  assign nack_o = s.nack;
  assign rd_data_o = s.rd_data;
  assign link.scl_host_o = 1'h0;
  assign link.scl_host_oe = s.scl_oe;
  assign link.sda_host_o = 1'h0;
  assign link.sda_host_oe = s.sda_oe;

endmodule

// [hdl/line_sampler.sv]
`timescale 1ns/10ps
module line_sampler (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Raw bus lines
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  // Synchronised levels and events
  output logic scl_o,
  output logic sda_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
  } sampler_regs_type;

  sampler_regs_type s;
  sampler_regs_type next_s;

  always_comb begin
    next_s.meta = {scl_pin_i, sda_pin_i};
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign scl_o = s.sync[1];
  assign sda_o = s.sync[0];
  assign scl_rise_o = s.sync[1] && !s.prev[1];
  assign scl_fall_o = !s.sync[1] && s.prev[1];
  // Line conditions with the clock high on both samples
  assign start_o = s.sync[1] && s.prev[1] && !s.sync[0] && s.prev[0];
  assign stop_o = s.sync[1] && s.prev[1] && s.sync[0] && !s.prev[0];

endmodule

// [include/divreg_pkg.sv]
package divreg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_POST_DIV_ADDR = 8'h05;
  localparam logic [7:0] REG_SECOND_DIV_ADDR = 8'h06;
  localparam logic [7:0] REG_ADDR_RESET = 8'h00;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int POST_DIV_MSB = 15;
  localparam int POST_DIV_LSB = 3;
  localparam int DRIVER_MSB = 2;
  localparam int DRIVER_LSB = 0;
  localparam int SECOND_DIV_BIT = 3;
  localparam int POST_DIV_W = 13;
  localparam int DRIVER_W = 3;
  // Stand-in for the factory-programmed post-divider start value
  localparam logic [12:0] POST_DIV_DEFAULT = 13'h0002;
  localparam logic [2:0] DRIVER_RESET = 3'h0;
  localparam logic SECOND_DIV_RESET = 1'h0;

  // ****************************************************************
  // Serial framing
  // ****************************************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam logic [7:0] BYTE_RELEASED = 8'hff;
  // Slave address; a plain default, strap it per board
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h60;

  // ****************************************************************
  // Host byte sequence steps
  // ****************************************************************
  localparam logic [2:0] STEP_DEV_WRITE = 3'h0;
  localparam logic [2:0] STEP_REG = 3'h1;
  localparam logic [2:0] STEP_THIRD = 3'h2;
  localparam logic [2:0] STEP_FOURTH = 3'h3;
  localparam logic [2:0] STEP_FIFTH = 3'h4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int REF_CLK_PERIOD_NS = 8;
  // Short quarters keep a whole frame under ten thousand clocks
  localparam int SCL_QUARTER_NS = 400;
  localparam int SCL_QUARTER_CYCLES =
    (SCL_QUARTER_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam logic [8:0] SCL_QUARTER_LOAD = 9'(SCL_QUARTER_CYCLES - 1);

endpackage

// [include/i2c_link_if.sv]
`timescale 1ns/10ps
interface i2c_link_if;

  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // Open-drain wired AND; a released line is pulled high
  assign scl = !(scl_host_oe && !scl_host_o);
  assign sda = !((sda_host_oe && !sda_host_o) ||
                 (sda_dev_oe && !sda_dev_o));

  modport device (
    input scl,
    input sda,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport host (
    input scl,
    input sda,
    output scl_host_o,
    output scl_host_oe,
    output sda_host_o,
    output sda_host_oe
  );

endinterface

// [testbench/i2c_link_assertions.sv]
`timescale 1ns/10ps
module i2c_link_assertions (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence start_seq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_seq;
    scl && $past(scl) && $rose(sda);
  endsequence

  // Sync plus edge stage puts device moves 3-4 cycles after a fall
  dev_edge_low_a: assert property (
    $changed(sda_dev_oe) |-> !scl && $past(scl, 5))
    else $error("device data moved off clock low");
  ack_hold_a: assert property (
    $rose(scl) && sda_dev_oe |-> sda_dev_oe [*8])
    else $error("device let go in clock high");
  scl_high_a: assert property (
    $rose(scl) |-> (scl && !scl_host_oe) [*8])
    else $error("clock high phase too short");
  start_bound_a: assert property (
    start_seq |-> ##[1:400] !scl)
    else $error("no clock after start");
  start_clear_a: assert property (
    start_seq |-> sda_host_oe && !sda_dev_oe)
    else $error("start not made by host alone");
  stop_idle_a: assert property (
    stop_seq |-> (scl && sda) [*8])
    else $error("bus not idle after stop");
  no_fight_a: assert property (
    scl |-> !(sda_host_oe && sda_dev_oe))
    else $error("both ends drive data in clock high");
  hold_high_a: assert property (
    scl && $past(scl) && $changed(sda) |->
      $changed(sda_host_oe) && !sda_dev_oe)
    else $error("data moved in clock high");
endmodule

// [testbench/i2c_slave_divider_regs_test.sv]
`timescale 1ns/10ps
module i2c_slave_divider_regs_test;
  localparam logic [6:0] DEV = divreg_pkg::DEVICE_ADDR_DEFAULT;
  localparam logic [7:0] POST_ADDR = divreg_pkg::REG_POST_DIV_ADDR;
  localparam logic [7:0] SEC_ADDR = divreg_pkg::REG_SECOND_DIV_ADDR;
  localparam logic [12:0] POST_INIT = divreg_pkg::POST_DIV_DEFAULT;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic cmd_read_i = 1'b0;
  logic [6:0] cmd_dev_addr_i = 7'h00;
  logic [7:0] cmd_reg_addr_i = 8'h00;
  logic [15:0] cmd_wdata_i = 16'h0000;
  logic cmd_ready_o, done_o, nack_o, sec_div;
  logic [15:0] rd_data_o, wd;
  logic [12:0] post_div;
  logic [2:0] post_drv, sec_drv;
  int fails = 0;
  int check_count = 0;

  i2c_link_if link();
  i2c_divider_device #(.DEVICE_ADDR(DEV)) i_i2c_divider_device (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .output_post_divider_o(post_div), .post_driver_select_o(post_drv),
    .second_output_divider_o(sec_div), .second_driver_select_o(sec_drv));
  i2c_divider_host i_i2c_divider_host (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_read_i(cmd_read_i), .cmd_dev_addr_i(cmd_dev_addr_i),
    .cmd_reg_addr_i(cmd_reg_addr_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o),
    .rd_data_o(rd_data_o), .link(link));
  i2c_link_assertions i_i2c_link_assertions (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl(link.scl), .sda(link.sda),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe),
    .sda_dev_oe(link.sda_dev_oe));

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // Unused upper bits of the second register always read back as zero
  function automatic logic [15:0] reg6_view(input logic [15:0] d);
    return {12'h000, d[3:0]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One word per command; a full frame runs under 10k cycles
  task automatic run_cmd(input logic rd, input logic [6:0] dev,
                         input logic [7:0] ra, input logic [15:0] d);
    int n;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b1;
    cmd_read_i = rd;
    cmd_dev_addr_i = dev;
    cmd_reg_addr_i = ra;
    cmd_wdata_i = d;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
    for (n = 0; n < 20000 && done_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (n == 20000) begin
      fails++;
      give_verdict();
    end
  endtask

  initial begin
    void'($urandom(37));
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk("ready", 16'h0001, {15'h0, cmd_ready_o});
    chk("post div", {3'h0, POST_INIT}, {3'h0, post_div});
    chk("post drv", 16'h0000, {13'h0, post_drv});
    chk("second reg", 16'h0000, {12'h0, sec_div, sec_drv});
    // Upper bits forced high to prove they are dropped
    wd = 16'($urandom) | 16'hfff0;
    run_cmd(1'b0, DEV, SEC_ADDR, wd);
    chk("write nack", 16'h0000, {15'h0, nack_o});
    chk("second reg", reg6_view(wd), {12'h0, sec_div, sec_drv});
    run_cmd(1'b1, DEV, SEC_ADDR, 16'h0000);
    chk("read word", reg6_view(wd), rd_data_o);
    run_cmd(1'b0, DEV ^ 7'h01, POST_ADDR, 16'hffff);
    chk("bad addr nack", 16'h0001, {15'h0, nack_o});
    chk("post drv", 16'h0000, {13'h0, post_drv});
    chk("post div", {3'h0, POST_INIT}, {3'h0, post_div});
    // Random words through the post-divider register, both ways
    repeat (2) begin
      wd = 16'($urandom);
      run_cmd(1'b0, DEV, POST_ADDR, wd);
      chk("post div", {3'h0, wd[15:3]}, {3'h0, post_div});
      chk("post drv", {13'h0, wd[2:0]}, {13'h0, post_drv});
      run_cmd(1'b1, DEV, POST_ADDR, 16'h0000);
      chk("read post", wd, rd_data_o);
      chk("read nack", 16'h0000, {15'h0, nack_o});
    end
    give_verdict();
  end
endmodule
